// ---- design/cal_pkg.sv ----
// package of constants for the concentration alarm relay block
// Contract
// R1: fixed range over its top clamps the analog output at full scale
// R2: digital and serial concentration always carry the true measured value
// R3: range type selects auto range switching or one fixed range
// R4: two configurable concentration alarms plus system failure alarm, one relay each
// R5: high alarm trips when concentration rises above its threshold
// R6: low alarm trips when concentration falls below its threshold
// R7: failsafe relay released during alarm, energised otherwise
// R8: non-failsafe relay energised during alarm, released otherwise
// R9: latching alarm holds after concentration recovers until reset
// R10: non-latching alarm clears as soon as concentration recovers
// R11: defeat suppresses activation and clears a latched alarm
// R12: thresholds accept 0.01 to 100.00 percent in hundredths
// R13: latch control ON means latching, OFF means non-latching
// R14: defeat control OFF means defeated, ON means active
// R15: read-only active status per alarm; reset only acts while active
// R16: operator clears an active alarm by a reset request
// R17: failsafe polarity selectable separately per alarm
// R18: defeated alarm holds its relay at the non-alarm level
package cal_pkg;
   localparam int CAL_CONC_W = 14;
   localparam logic [13:0] CAL_THR_MIN = 14'h0001;
   localparam logic [13:0] CAL_THR_MAX = 14'h2710;
   localparam logic [15:0] CAL_AOUT_FS = 16'hFFFF;
   localparam logic [31:0] CAL_RANGE0_RST = 32'h0000_0064;
   localparam logic [31:0] CAL_RANGE1_RST = 32'h0000_01F4;
   localparam logic [31:0] CAL_RANGE2_RST = 32'h0000_03E8;
   localparam logic [11:0] CAL_A_CONC = 12'h000;
   localparam logic [11:0] CAL_A_CTRL = 12'h004;
   localparam logic [11:0] CAL_A_THR1 = 12'h008;
   localparam logic [11:0] CAL_A_THR2 = 12'h00C;
   localparam logic [11:0] CAL_A_ALCFG = 12'h010;
   localparam logic [11:0] CAL_A_STAT = 12'h014;
   localparam logic [11:0] CAL_A_RESET = 12'h018;
   localparam logic [11:0] CAL_A_ISTAT = 12'h01C;
   localparam logic [11:0] CAL_A_IMASK = 12'h020;
   localparam logic [11:0] CAL_A_RANGE0 = 12'h024;
   localparam logic [11:0] CAL_A_RANGE1 = 12'h028;
   localparam logic [11:0] CAL_A_RANGE2 = 12'h02C;
   localparam logic [11:0] CAL_A_AOUT = 12'h030;
   // ctrl fields
   localparam int CAL_CTRL_FIXED = 0;
   localparam int CAL_CTRL_FSEL = 1;
   localparam int CAL_CTRL_SYSFAIL = 3;
   // alarm config: per alarm byte, alarm n at bit 8*n
   localparam int CAL_CFG_HIGH = 0;
   localparam int CAL_CFG_ACTIVE = 1;
   localparam int CAL_CFG_FAILSAFE = 2;
   localparam int CAL_CFG_LATCH = 3;
   localparam logic [31:0] CAL_ALCFG_RST = 32'h0000_0303;
   localparam logic [13:0] CAL_THR_RST = 14'h07D0;
   localparam logic [1:0] CAL_RESP_OKAY = 2'h0;
   localparam logic [1:0] CAL_RESP_SLVERR = 2'h2;
endpackage

// ---- design/cal_alarm_unit.sv ----
// one concentration alarm: compare, latch, defeat, relay polarity
`timescale 1ns/1ps
`default_nettype none
module cal_alarm_unit (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [cal_pkg::CAL_CONC_W-1:0] conc,
   input wire logic [cal_pkg::CAL_CONC_W-1:0] thr,
   input wire logic cfg_high,
   input wire logic cfg_active,
   input wire logic cfg_failsafe,
   input wire logic cfg_latch,
   input wire logic reset_req,
   output logic alarm_active,
   output logic trip_pulse,
   output logic relay_drive
);
   import cal_pkg::*;
   logic act_q, act_d, over, under, cond;
   assign over = conc > thr;
   assign under = conc < thr;
   // see R5 see R6
   assign cond = cfg_high ? over : under;
   always_comb begin
      act_d = act_q;
      if (!cfg_active) begin
         act_d = 1'b0; // see R11 see R14
      end else if (cond) begin
         act_d = 1'b1; // trip wins over reset
      end else if (!cfg_latch) begin
         act_d = 1'b0; // see R10 see R13
      end else if (reset_req && act_q) begin
         act_d = 1'b0; // see R9 see R15 see R16
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_q <= 1'b0;
      end else begin
         act_q <= act_d;
      end
   end
   assign trip_pulse = act_d && !act_q;
   assign alarm_active = act_q;
   // defeat forces act_q low, so relay sits at non-alarm level; see R18
   // see R7 see R8 see R17
   assign relay_drive = cfg_failsafe ? !act_q : act_q;
   AST_DEFEAT_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
      !cfg_active |=> !act_q) else $error("defeated alarm still active"); // see R11
   AST_RELAY_POL: assert property (@(posedge aclk) disable iff (!aresetn) // see R18
      !cfg_active |=> relay_drive == cfg_failsafe) else $error("defeated relay not at rest");
   AST_TRIP_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_active && cfg_high && (conc > thr) |=> act_q) else $error("high alarm missed"); // see R5
   AST_TRIP_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_active && !cfg_high && (conc < thr) |=> act_q) else $error("low alarm missed"); // see R6
   AST_NOLATCH: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_active && !cfg_latch && !cond |=> !act_q) else $error("nonlatch held"); // see R10
   AST_LATCH_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      act_q && cfg_active && cfg_latch && !reset_req |=> act_q)
      else $error("latched alarm dropped"); // see R9
   COV_TRIP: cover property (@(posedge aclk) disable iff (!aresetn) !act_q ##1 act_q);
   COV_LATCH_RST: cover property (@(posedge aclk) disable iff (!aresetn)
      act_q && cfg_latch && reset_req && !cond ##1 !act_q);
endmodule // cal_alarm_unit
`default_nettype wire

// ---- design/cal_top.sv ----
// concentration alarm relays and analog range logic behind an axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module cal_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [cal_pkg::CAL_CONC_W-1:0] conc_in,
   input wire logic conc_valid,
   output logic [cal_pkg::CAL_CONC_W-1:0] conc_report,
   output logic [15:0] analog_out,
   output logic [1:0] range_id,
   output logic relay1_drive,
   output logic relay2_drive,
   output logic sysfail_relay,
   output logic irq
);
   import cal_pkg::*;

   // ----------------------------------------
   // register state
   // ----------------------------------------
   logic [31:0] ctrl_q, alcfg_q, istat_q, imask_q;
   logic [31:0] range_q [3];
   logic [13:0] thr_q [2];
   logic [13:0] conc_q;
   logic [15:0] aout_q;
   logic [1:0] rid_q;

   // ----------------------------------------
   // axi write path
   // ----------------------------------------
   logic aw_held_q, w_held_q, bvalid_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   wire logic wr_fire = aw_held_q && w_held_q && !bvalid_q;
   wire logic [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
      {8{wstrb_q[0]}}};
   wire logic wr_ctrl = wr_fire && awaddr_q == CAL_A_CTRL;
   wire logic wr_thr1 = wr_fire && awaddr_q == CAL_A_THR1;
   wire logic wr_thr2 = wr_fire && awaddr_q == CAL_A_THR2;
   wire logic wr_cfg = wr_fire && awaddr_q == CAL_A_ALCFG;
   wire logic wr_rst = wr_fire && awaddr_q == CAL_A_RESET;
   wire logic wr_ist = wr_fire && awaddr_q == CAL_A_ISTAT;
   wire logic wr_imk = wr_fire && awaddr_q == CAL_A_IMASK;
   wire logic wr_r0 = wr_fire && awaddr_q == CAL_A_RANGE0;
   wire logic wr_r1 = wr_fire && awaddr_q == CAL_A_RANGE1;
   wire logic wr_r2 = wr_fire && awaddr_q == CAL_A_RANGE2;
   wire logic wr_known = wr_ctrl || wr_thr1 || wr_thr2 || wr_cfg || wr_rst || wr_ist
      || wr_imk || wr_r0 || wr_r1 || wr_r2;
   wire logic [31:0] wmerge_ctrl = (ctrl_q & ~wmask) | (wdata_q & wmask);
   wire logic [31:0] wmerge_cfg = (alcfg_q & ~wmask) | (wdata_q & wmask);
   wire logic [31:0] wmerge_imk = (imask_q & ~wmask) | (wdata_q & wmask);
   wire logic [31:0] wnew = wdata_q & wmask;

   // threshold legal only inside 0.01..100.00; out of range writes are dropped
   function automatic logic thr_ok(input logic [31:0] v);
      thr_ok = v[31:14] == 18'h0 && v[13:0] >= CAL_THR_MIN && v[13:0] <= CAL_THR_MAX;
   endfunction

   assign s_axi_awready = !aw_held_q;
   assign s_axi_wready = !w_held_q;
   assign s_axi_bvalid = bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         bvalid_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bresp <= CAL_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            s_axi_bresp <= wr_known ? CAL_RESP_OKAY : CAL_RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= 32'h0000_0000;
         alcfg_q <= CAL_ALCFG_RST;
         imask_q <= 32'h0000_0000;
         thr_q[0] <= CAL_THR_RST;
         thr_q[1] <= CAL_THR_RST;
         range_q[0] <= CAL_RANGE0_RST;
         range_q[1] <= CAL_RANGE1_RST;
         range_q[2] <= CAL_RANGE2_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wmerge_ctrl & 32'h0000_000F; // see R3
         end
         if (wr_cfg) begin
            alcfg_q <= wmerge_cfg & 32'h0000_0F0F; // see R13 see R14 see R17
         end
         if (wr_imk) begin
            imask_q <= wmerge_imk & 32'h0000_0003;
         end
         if (wr_thr1 && thr_ok(wnew)) begin
            thr_q[0] <= wnew[13:0]; // see R12
         end
         if (wr_thr2 && thr_ok(wnew)) begin
            thr_q[1] <= wnew[13:0]; // see R12
         end
         if (wr_r0 && thr_ok(wnew)) begin
            range_q[0] <= wnew;
         end
         if (wr_r1 && thr_ok(wnew)) begin
            range_q[1] <= wnew;
         end
         if (wr_r2 && thr_ok(wnew)) begin
            range_q[2] <= wnew;
         end
      end
   end

   // ----------------------------------------
   // measurement capture
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conc_q <= 14'h0000;
      end else if (conc_valid) begin
         conc_q <= conc_in;
      end
   end
   // reported value is the raw sample, never range scaled; see R2
   assign conc_report = conc_q;

   // ----------------------------------------
   // alarms
   // ----------------------------------------
   logic [1:0] act, trip, relay;
   wire logic [1:0] rst_req = {2{wr_rst}} & wnew[1:0];
   // see R4
   for (genvar g = 0; g < 2; g++) begin : g_alarm
      cal_alarm_unit u_alarm (
         .aclk(aclk),
         .aresetn(aresetn),
         .conc(conc_q),
         .thr(thr_q[g]),
         .cfg_high(alcfg_q[8*g+CAL_CFG_HIGH]),
         .cfg_active(alcfg_q[8*g+CAL_CFG_ACTIVE]),
         .cfg_failsafe(alcfg_q[8*g+CAL_CFG_FAILSAFE]),
         .cfg_latch(alcfg_q[8*g+CAL_CFG_LATCH]),
         .reset_req(rst_req[g]),
         .alarm_active(act[g]),
         .trip_pulse(trip[g]),
         .relay_drive(relay[g])
      );
   end
   assign relay1_drive = relay[0];
   assign relay2_drive = relay[1];
   // system failure relay is a plain failsafe output driven by software; see R4
   assign sysfail_relay = !ctrl_q[CAL_CTRL_SYSFAIL];

   // ----------------------------------------
   // interrupt status, write one to clear
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         istat_q <= 32'h0000_0000;
      end else begin
         // set wins over clear so a trip in the clear cycle survives
         istat_q <= (istat_q & ~({30'h0, {2{wr_ist}} & wnew[1:0]})) | {30'h0, trip};
      end
   end
   assign irq = |(istat_q & imask_q);

   // ----------------------------------------
   // analog output ranging
   // ----------------------------------------
   // auto ranging: first of range 0 and range 1 whose top covers the value, else range 2
   wire logic fixed = ctrl_q[CAL_CTRL_FIXED];
   wire logic [1:0] fsel = ctrl_q[CAL_CTRL_FSEL+1:CAL_CTRL_FSEL];
   wire logic [1:0] auto_id = ({18'h0, conc_q} <= range_q[0]) ? 2'd0 :
      ({18'h0, conc_q} <= range_q[1]) ? 2'd1 : 2'd2;
   wire logic [1:0] rid_d = fixed ? (fsel == 2'd3 ? 2'd2 : fsel) : auto_id; // see R3
   wire logic [13:0] top = range_q[rid_d][13:0];
   wire logic sat = conc_q >= top;
   // divider kept simple: scale by 65535/top via a wide product then a divide
   wire logic [29:0] prod = {16'h0, conc_q} * 30'd65535;
   wire logic [29:0] quot = prod / {16'h0, top};
   wire logic [15:0] aout_d = sat ? CAL_AOUT_FS : quot[15:0]; // see R1
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aout_q <= 16'h0000;
         rid_q <= 2'd0;
      end else begin
         aout_q <= aout_d;
         rid_q <= rid_d;
      end
   end
   assign analog_out = aout_q;
   assign range_id = rid_q;

   // ----------------------------------------
   // axi read path
   // ----------------------------------------
   logic rvalid_q;
   wire logic rd_fire = s_axi_arvalid && !rvalid_q;
   wire logic [11:0] ra = {s_axi_araddr[11:2], 2'b00};
   wire logic rd_known = ra == CAL_A_CONC || ra == CAL_A_CTRL || ra == CAL_A_THR1
      || ra == CAL_A_THR2 || ra == CAL_A_ALCFG || ra == CAL_A_STAT || ra == CAL_A_RESET
      || ra == CAL_A_ISTAT || ra == CAL_A_IMASK || ra == CAL_A_RANGE0
      || ra == CAL_A_RANGE1 || ra == CAL_A_RANGE2 || ra == CAL_A_AOUT;
   wire logic [31:0] rd_mux =
      ra == CAL_A_CONC ? {18'h0, conc_q} :
      ra == CAL_A_CTRL ? ctrl_q :
      ra == CAL_A_THR1 ? {18'h0, thr_q[0]} :
      ra == CAL_A_THR2 ? {18'h0, thr_q[1]} :
      ra == CAL_A_ALCFG ? alcfg_q :
      ra == CAL_A_STAT ? {30'h0, act} : // see R15
      ra == CAL_A_ISTAT ? istat_q :
      ra == CAL_A_IMASK ? imask_q :
      ra == CAL_A_RANGE0 ? range_q[0] :
      ra == CAL_A_RANGE1 ? range_q[1] :
      ra == CAL_A_RANGE2 ? range_q[2] :
      ra == CAL_A_AOUT ? {14'h0, rid_q, aout_q} : 32'h0000_0000;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= CAL_RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_q <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_known ? CAL_RESP_OKAY : CAL_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_FIXED_CLAMP: assert property (@(posedge aclk) disable iff (!aresetn)
      fixed && conc_q >= top |=> analog_out == CAL_AOUT_FS) else $error("no clamp"); // see R1
   AST_FIXED_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
      fixed && fsel != 2'd3 |=> range_id == $past(fsel)) else $error("range moved"); // see R3
   AST_TRUE_CONC: assert property (@(posedge aclk) disable iff (!aresetn)
      conc_valid |=> conc_report == $past(conc_in)) else $error("report altered"); // see R2
   AST_STAT_REFLECT: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_fire && ra == CAL_A_STAT |=> s_axi_rdata[1:0] == $past(act))
      else $error("status read wrong"); // see R15
   AST_IRQ_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
      trip[0] && imask_q[0] && !wr_imk |=> irq) else $error("irq missed"); // see R4
   AST_BRESP: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> bvalid_q) else $error("no write answer");
   COV_FIXED_SAT: cover property (@(posedge aclk) disable iff (!aresetn) fixed && sat);
   COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) !irq ##1 irq);
endmodule // cal_top
`default_nettype wire

// ---- dv/cal_panel_model.sv ----
// sensor and operator panel side model feeding concentration samples
`timescale 1ns/1ps
`default_nettype none
module cal_panel_model (
   input wire logic aclk,
   output logic [cal_pkg::CAL_CONC_W-1:0] conc_in,
   output logic conc_valid
);
   import cal_pkg::*;
   initial begin
      conc_in = '0;
      conc_valid = 1'b0;
   end
   // one sample per call, then settle time for alarm and analog paths
   // idle data is inverted so a stale value never passes as a fresh one
   task automatic set_conc(input logic [CAL_CONC_W-1:0] v);
      conc_in <= v;
      conc_valid <= 1'b1;
      @(posedge aclk);
      conc_valid <= 1'b0;
      conc_in <= ~v;
      repeat (4) @(posedge aclk);
   endtask
endmodule // cal_panel_model
`default_nettype wire

// ---- dv/concentration_alarm_relay_logic_tb.sv ----
// self-checking bench for the concentration alarm relay block
`timescale 1ns/1ps
`default_nettype none
module concentration_alarm_relay_logic_tb;
   import cal_pkg::*;
   // ----------------
   // signals
   // ----------------
   typedef struct packed {
      logic [31:0] cfg;
      logic [13:0] conc;
      logic r1;
      logic r2;
      logic [1:0] st;
   } cal_row_s;
   logic aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic conc_valid, relay1, relay2, sysfail, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp, range_id;
   logic [13:0] conc_in, conc_report;
   logic [15:0] aout;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   cal_row_s rows [7];
   cal_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .conc_in(conc_in), .conc_valid(conc_valid),
      .conc_report(conc_report), .analog_out(aout), .range_id(range_id),
      .relay1_drive(relay1), .relay2_drive(relay2), .sysfail_relay(sysfail), .irq(irq));
   cal_panel_model i_panel (.aclk(aclk), .conc_in(conc_in), .conc_valid(conc_valid));
   // ----------------
   // clock, watchdog, tasks
   // ----------------
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // whole run needs well under 2000 cycles
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         end_of_test;
      end
   end
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_val({31'h0, got}, {31'h0, exp});
   endtask
   // ready rises with each request and drops one edge after the answer,
   // so the next call never re-raises it in the same time step
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            break;
         end
      end
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rdr(input logic [11:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rd = rdata;
            resp = rresp;
            break;
         end
      end
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   // ----------------
   // main sequence
   // ----------------
   initial begin
      aresetn = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      bready = 1'b0;
      rready = 1'b0;
      rows[0] = '{32'h0000_0303, 14'h09C4, 1'b1, 1'b0, 2'h1};
      rows[1] = '{32'h0000_0707, 14'h0DAC, 1'b0, 1'b0, 2'h3};
      rows[2] = '{32'h0000_0202, 14'h09C4, 1'b0, 1'b1, 2'h2};
      rows[3] = '{32'h0000_0606, 14'h03E8, 1'b0, 1'b0, 2'h3};
      rows[4] = '{32'h0000_0307, 14'h07D0, 1'b1, 1'b0, 2'h0};
      rows[5] = '{32'h0000_0101, 14'h2328, 1'b0, 1'b0, 2'h0};
      rows[6] = '{32'h0000_0505, 14'h2328, 1'b1, 1'b1, 2'h0};
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk_bit(relay1, 1'b0);
      chk_bit(sysfail, 1'b1);
      chk_bit(irq, 1'b0);
      rdr(CAL_A_ALCFG);
      chk_val(rd, CAL_ALCFG_RST);
      wr(CAL_A_THR2, 32'h0000_0BB8);
      // direction, polarity and defeat table; thresholds 20.00 and 30.00
      foreach (rows[i]) begin
         wr(CAL_A_ALCFG, rows[i].cfg);
         i_panel.set_conc(rows[i].conc);
         chk_bit(relay1, rows[i].r1);
         chk_bit(relay2, rows[i].r2);
         chk_val(32'(conc_report), 32'(rows[i].conc));
         rdr(CAL_A_STAT);
         chk_val(rd, {30'h0, rows[i].st});
      end
      // latching: reset refused while the condition persists
      i_panel.set_conc(14'h03E8);
      wr(CAL_A_ALCFG, 32'h0000_0B0B);
      i_panel.set_conc(14'h09C4);
      wr(CAL_A_RESET, 32'h0000_0001);
      rdr(CAL_A_STAT);
      chk_val(rd, 32'h0000_0001);
      i_panel.set_conc(14'h03E8);
      rdr(CAL_A_STAT);
      chk_val(rd, 32'h0000_0001);
      chk_bit(relay1, 1'b1);
      wr(CAL_A_RESET, 32'h0000_0001);
      rdr(CAL_A_STAT);
      chk_val(rd, 32'h0000_0000);
      i_panel.set_conc(14'h09C4);
      i_panel.set_conc(14'h03E8);
      wr(CAL_A_ALCFG, 32'h0000_0909);
      rdr(CAL_A_STAT);
      chk_val(rd, 32'h0000_0000);
      chk_bit(relay1, 1'b0);
      // interrupt: unmask, clear, masked trip, unmask again
      wr(CAL_A_IMASK, 32'h0000_0001);
      chk_bit(irq, 1'b1);
      wr(CAL_A_ISTAT, 32'h0000_0001);
      chk_bit(irq, 1'b0);
      wr(CAL_A_IMASK, 32'h0000_0000);
      wr(CAL_A_ALCFG, 32'h0000_0B0B);
      i_panel.set_conc(14'h09C4);
      chk_bit(irq, 1'b0);
      rdr(CAL_A_ISTAT);
      chk_val(rd & 32'h0000_0001, 32'h0000_0001);
      wr(CAL_A_IMASK, 32'h0000_0001);
      chk_bit(irq, 1'b1);
      // unmapped place and threshold bounds
      wr(12'h0FC, 32'h0000_0001);
      chk_val(32'(resp), 32'(CAL_RESP_SLVERR));
      rdr(12'h0FC);
      chk_val(32'(resp), 32'(CAL_RESP_SLVERR));
      chk_val(rd, 32'h0000_0000);
      wr(CAL_A_THR1, 32'h0000_2711);
      chk_val(32'(resp), 32'(CAL_RESP_OKAY));
      rdr(CAL_A_THR1);
      chk_val(rd, 32'h0000_07D0);
      wr(CAL_A_THR2, 32'h0000_2710);
      rdr(CAL_A_THR2);
      chk_val(rd, 32'h0000_2710);
      // byte lanes: only the second alarm's byte may change
      wstrb <= 4'h2;
      wr(CAL_A_ALCFG, 32'h0000_0100);
      wstrb <= 4'hF;
      rdr(CAL_A_ALCFG);
      chk_val(rd, 32'h0000_010B);
      // fixed and auto analog ranges
      wr(CAL_A_CTRL, 32'h0000_0001);
      i_panel.set_conc(14'h0096);
      chk_val(32'(aout), 32'h0000_FFFF);
      chk_val(32'(conc_report), 32'h0000_0096);
      chk_val(32'(range_id), 32'h0000_0000);
      i_panel.set_conc(14'h0032);
      chk_val(32'(aout), 32'h0000_7FFF);
      wr(CAL_A_CTRL, 32'h0000_0003);
      i_panel.set_conc(14'h0258);
      chk_val(32'(aout), 32'h0000_FFFF);
      chk_val(32'(range_id), 32'h0000_0001);
      wr(CAL_A_CTRL, 32'h0000_0000);
      i_panel.set_conc(14'h012C);
      chk_val(32'(range_id), 32'h0000_0001);
      chk_val(32'(aout), 32'h0000_9999);
      wr(CAL_A_CTRL, 32'h0000_0008);
      chk_bit(sysfail, 1'b0);
      // mid-run reset brings every output back to its idle value
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk_bit(sysfail, 1'b1);
      chk_bit(relay1, 1'b0);
      chk_bit(relay2, 1'b0);
      chk_bit(irq, 1'b0);
      chk_val(32'(aout), 32'h0000_0000);
      chk_val(32'(range_id), 32'h0000_0000);
      chk_val(32'(conc_report), 32'h0000_0000);
      rdr(CAL_A_STAT);
      chk_val(rd, 32'h0000_0000);
      rdr(CAL_A_ALCFG);
      chk_val(rd, CAL_ALCFG_RST);
      end_of_test;
   end
endmodule // concentration_alarm_relay_logic_tb
`default_nettype wire
